/* design/jdb_pkg.sv */
// Shared constants, TAP states and carrier structs for the debug and boundary scan port.
package jdb_pkg;
   localparam int IR_W = 4;
   localparam logic [3:0] IR_EXTEST = 4'h0;
   localparam logic [3:0] IR_WAKE = 4'h1;
   localparam logic [3:0] IR_BOOT = 4'h2;
   localparam logic [3:0] IR_SAMPLE = 4'h4;
   localparam logic [3:0] IR_INT = 4'h5;
   localparam logic [3:0] IR_RST_ON = 4'h6;
   localparam logic [3:0] IR_RST_OFF = 4'h7;
   localparam logic [3:0] IR_BYPASS = 4'hF;
   localparam logic [3:0] IR_CAPTURE_PAT = 4'h1;
   localparam logic [3:0] IRQ_PRIORITY = 4'hF;
   localparam logic [3:0] IRQ_LEVEL_RST = 4'h0;
   localparam int BS_PINS = 8;
   localparam int BS_LEN = 3 * BS_PINS + 1;
   localparam int BS_CLK_CELL = 0;
   localparam int BS_IN_OFS = 1;
   localparam int BS_OUT_OFS = 2;
   localparam int BS_CTL_OFS = 3;
   localparam int BS_STRIDE = 3;

   typedef enum logic [3:0] {
      TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR, TAP_PAUSE_DR, TAP_EXIT2_DR,
      TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
   } jdb_tap_e;

   typedef struct packed {
      logic [BS_PINS-1:0] pin_in;
      logic bus_clk;
      logic emu_sel;
      logic por_n;
      logic trst_n;
      logic tdi;
      logic tms;
      logic tck;
   } jdb_pin_s;

   typedef struct packed {
      logic capture;
      logic shift;
      logic update;
      logic tdi;
   } jdb_bs_ctl_s;
endpackage : jdb_pkg

/* design/jdb_sync.sv */
// Two-flop synchroniser for every pin that enters the reference clock domain.
`timescale 1ns/1ps
module jdb_sync (
   input wire logic ref_clk,
   input wire logic srst,
   input jdb_pkg::jdb_pin_s async_in,
   output jdb_pkg::jdb_pin_s sync_out
);
   localparam int W = $bits(jdb_pkg::jdb_pin_s);
   logic [W-1:0] in_bits;
   logic [W-1:0] out_bits;
   // Emulator select clears to main mode, so cleared pins never look like a reset-hold request.
   localparam jdb_pkg::jdb_pin_s RST_PINS = '{emu_sel: 1'b1, default: '0};
   localparam logic [W-1:0] RST_BITS = RST_PINS;

   assign in_bits = async_in;
   assign sync_out = out_bits;

   for (genvar i = 0; i < W; i++)
   begin : g_bit
      logic meta_ff;
      logic sync_ff;
      always_ff @(posedge ref_clk)
      begin
         if (srst)
         begin
            meta_ff <= RST_BITS[i];
            sync_ff <= RST_BITS[i];
         end
         else
         begin
            meta_ff <= in_bits[i];
            sync_ff <= meta_ff;
         end
      end
      assign out_bits[i] = sync_ff;
   end
endmodule : jdb_sync

/* design/jdb_bscan.sv */
// Boundary scan chain with capture, shift and parallel output latches.
`timescale 1ns/1ps
module jdb_bscan (
   input wire logic ref_clk,
   input wire logic srst,
   input jdb_pkg::jdb_bs_ctl_s ctl,
   input wire logic bus_clk,
   input wire logic [jdb_pkg::BS_PINS-1:0] pin_in,
   input wire logic [jdb_pkg::BS_PINS-1:0] core_out,
   input wire logic [jdb_pkg::BS_PINS-1:0] core_oe_n,
   output logic [1:0] chain_low,
   output logic [jdb_pkg::BS_PINS-1:0] out_latch,
   output logic [jdb_pkg::BS_PINS-1:0] oe_n_latch
);
   logic [jdb_pkg::BS_LEN-1:0] chain_ff;
   logic [jdb_pkg::BS_PINS-1:0] out_latch_ff;
   logic [jdb_pkg::BS_PINS-1:0] oe_n_latch_ff;

   always_ff @(posedge ref_clk)
   begin
      if (srst)
         chain_ff[jdb_pkg::BS_CLK_CELL] <= 1'b0;
      else if (ctl.capture)
         chain_ff[jdb_pkg::BS_CLK_CELL] <= bus_clk;
      else if (ctl.shift)
         chain_ff[jdb_pkg::BS_CLK_CELL] <= chain_ff[jdb_pkg::BS_CLK_CELL+1];
   end

   for (genvar p = 0; p < jdb_pkg::BS_PINS; p++)
   begin : g_pin
      localparam int IC = jdb_pkg::BS_IN_OFS + jdb_pkg::BS_STRIDE * p;
      localparam int OC = jdb_pkg::BS_OUT_OFS + jdb_pkg::BS_STRIDE * p;
      localparam int CC = jdb_pkg::BS_CTL_OFS + jdb_pkg::BS_STRIDE * p;
      always_ff @(posedge ref_clk)
      begin
         if (srst)
         begin
            chain_ff[IC] <= 1'b0;
            chain_ff[OC] <= 1'b0;
            chain_ff[CC] <= 1'b1;
         end
         else if (ctl.capture)
         begin
            chain_ff[IC] <= pin_in[p];
            chain_ff[OC] <= core_out[p];
            chain_ff[CC] <= core_oe_n[p];
         end
         else if (ctl.shift)
         begin
            chain_ff[IC] <= chain_ff[IC+1];
            chain_ff[OC] <= chain_ff[OC+1];
            chain_ff[CC] <= (CC == jdb_pkg::BS_LEN - 1) ? ctl.tdi : chain_ff[(CC+1) % jdb_pkg::BS_LEN];
         end
      end
      always_ff @(posedge ref_clk)
      begin
         if (srst)
         begin
            out_latch_ff[p] <= 1'b0;
            oe_n_latch_ff[p] <= 1'b1;
         end
         else if (ctl.update)
         begin
            out_latch_ff[p] <= chain_ff[OC];
            oe_n_latch_ff[p] <= chain_ff[CC];
         end
      end
   end

   assign chain_low = chain_ff[1:0];
   assign out_latch = out_latch_ff;
   assign oe_n_latch = oe_n_latch_ff;
endmodule : jdb_bscan

/* design/jdb_top.sv */
// Serial debug port: TAP controller, command register, reset control and boundary scan.
// Function
// - TAP follows standard state diagram on TMS
// - TDI sampled rising, shift and TDO falling
// - TDO driven only in shift states
// - Test reset low forces test-logic-reset
// - Main mode reset pin combinations decoded
// - Emulator select high main, low emulator
// - Emulator mode both low enters hold
// - Hold ends on boot or fresh reset
// - Reset command holds chip reset until negate; test reset low also clears it
// - Interrupt command requests priority 15 exception
// - Interrupts ignored in sleep or standby
// - Code 0001 wakes chip from sleep
// - Code 1111 selects one-bit bypass
// - Code 0100 sample/preload, pins stay normal
// - Sample captures pin values in capture
// - Preload fills parallel output latches
// - Code 0000 extest drives latches, captures inputs
// - Extest shifts results out, next in
// - Chain has clock pin, no reset/debug pins
// - Commands persist; interrupt reverts to bypass
// - Standby ignores commands, TAP still runs
// - Low enable cell drives pin from data
`timescale 1ns/1ps
module jdb_top (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   input wire logic trst_n,
   output logic tdo,
   output logic tdo_oe,
   input wire logic power_on_reset_pin_n,
   input wire logic emulator_mode_select,
   input wire logic bus_clock_pin,
   input wire logic chip_sleep,
   input wire logic chip_standby,
   input wire logic [jdb_pkg::BS_PINS-1:0] pin_in,
   output logic [jdb_pkg::BS_PINS-1:0] pin_out,
   output logic [jdb_pkg::BS_PINS-1:0] pin_oe,
   input wire logic [jdb_pkg::BS_PINS-1:0] core_out,
   input wire logic [jdb_pkg::BS_PINS-1:0] core_oe_n,
   output logic [jdb_pkg::BS_PINS-1:0] core_in,
   output logic chip_reset,
   output logic debug_reset,
   output logic cpu_hold,
   output logic debug_irq,
   output logic [3:0] debug_irq_level,
   output logic wake_req,
   output logic [jdb_pkg::IR_W-1:0] debug_instruction_reg
);
   jdb_pkg::jdb_pin_s pins_raw;
   jdb_pkg::jdb_pin_s pins_s;
   jdb_pkg::jdb_bs_ctl_s bs_ctl;
   jdb_pkg::jdb_tap_e state_ff;
   jdb_pkg::jdb_tap_e nxt_state;
   logic tck_d_ff;
   logic tck_rise;
   logic tck_fall;
   logic tdi_ff;
   logic shift_dr_pend_ff;
   logic shift_ir_pend_ff;
   logic [jdb_pkg::IR_W-1:0] ir_sr_ff;
   logic [jdb_pkg::IR_W-1:0] ir_ff;
   logic bypass_ff;
   logic sel_bs;
   logic [1:0] bs_low;
   logic [jdb_pkg::BS_PINS-1:0] out_latch;
   logic [jdb_pkg::BS_PINS-1:0] oe_n_latch;
   logic tdo_ff;
   logic tdo_oe_ff;
   logic ir_load;
   logic rst_cmd_ff;
   logic hold_ff;
   logic por_d_ff;
   logic boot_ff;
   logic irq_ff;
   logic [3:0] irq_level_ff;
   logic wake_ff;
   logic chip_reset_ff;
   logic debug_reset_ff;
   logic cpu_hold_ff;
   logic [jdb_pkg::BS_PINS-1:0] pin_out_ff;
   logic [jdb_pkg::BS_PINS-1:0] pin_oe_ff;
   logic [jdb_pkg::BS_PINS-1:0] core_in_ff;

   assign pins_raw = '{pin_in: pin_in, bus_clk: bus_clock_pin, emu_sel: emulator_mode_select,
                       por_n: power_on_reset_pin_n, trst_n: trst_n, tdi: tdi, tms: tms, tck: tck};

   jdb_sync u_sync (
      .ref_clk(ref_clk),
      .srst(srst),
      .async_in(pins_raw),
      .sync_out(pins_s)
   );

   // The test clock is only sampled, so it must stay well below half the reference rate.
   always_ff @(posedge ref_clk)
   begin
      if (srst)
         tck_d_ff <= 1'b0;
      else
         tck_d_ff <= pins_s.tck;
   end
   assign tck_rise = pins_s.tck & ~tck_d_ff;
   assign tck_fall = ~pins_s.tck & tck_d_ff;

   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff)
         jdb_pkg::TAP_RESET: nxt_state = pins_s.tms ? jdb_pkg::TAP_RESET : jdb_pkg::TAP_IDLE;
         jdb_pkg::TAP_IDLE: nxt_state = pins_s.tms ? jdb_pkg::TAP_SEL_DR : jdb_pkg::TAP_IDLE;
         jdb_pkg::TAP_SEL_DR: nxt_state = pins_s.tms ? jdb_pkg::TAP_SEL_IR : jdb_pkg::TAP_CAP_DR;
         jdb_pkg::TAP_CAP_DR: nxt_state = pins_s.tms ? jdb_pkg::TAP_EXIT1_DR : jdb_pkg::TAP_SHIFT_DR;
         jdb_pkg::TAP_SHIFT_DR: nxt_state = pins_s.tms ? jdb_pkg::TAP_EXIT1_DR : jdb_pkg::TAP_SHIFT_DR;
         jdb_pkg::TAP_EXIT1_DR: nxt_state = pins_s.tms ? jdb_pkg::TAP_UPD_DR : jdb_pkg::TAP_PAUSE_DR;
         jdb_pkg::TAP_PAUSE_DR: nxt_state = pins_s.tms ? jdb_pkg::TAP_EXIT2_DR : jdb_pkg::TAP_PAUSE_DR;
         jdb_pkg::TAP_EXIT2_DR: nxt_state = pins_s.tms ? jdb_pkg::TAP_UPD_DR : jdb_pkg::TAP_SHIFT_DR;
         jdb_pkg::TAP_UPD_DR: nxt_state = pins_s.tms ? jdb_pkg::TAP_SEL_DR : jdb_pkg::TAP_IDLE;
         jdb_pkg::TAP_SEL_IR: nxt_state = pins_s.tms ? jdb_pkg::TAP_RESET : jdb_pkg::TAP_CAP_IR;
         jdb_pkg::TAP_CAP_IR: nxt_state = pins_s.tms ? jdb_pkg::TAP_EXIT1_IR : jdb_pkg::TAP_SHIFT_IR;
         jdb_pkg::TAP_SHIFT_IR: nxt_state = pins_s.tms ? jdb_pkg::TAP_EXIT1_IR : jdb_pkg::TAP_SHIFT_IR;
         jdb_pkg::TAP_EXIT1_IR: nxt_state = pins_s.tms ? jdb_pkg::TAP_UPD_IR : jdb_pkg::TAP_PAUSE_IR;
         jdb_pkg::TAP_PAUSE_IR: nxt_state = pins_s.tms ? jdb_pkg::TAP_EXIT2_IR : jdb_pkg::TAP_PAUSE_IR;
         jdb_pkg::TAP_EXIT2_IR: nxt_state = pins_s.tms ? jdb_pkg::TAP_UPD_IR : jdb_pkg::TAP_SHIFT_IR;
         jdb_pkg::TAP_UPD_IR: nxt_state = pins_s.tms ? jdb_pkg::TAP_SEL_DR : jdb_pkg::TAP_IDLE;
         default: nxt_state = jdb_pkg::TAP_RESET;
      endcase
   end

   always_ff @(posedge ref_clk)
   begin
      if (srst || !pins_s.trst_n)
         state_ff <= jdb_pkg::TAP_RESET;
      else if (tck_rise)
         state_ff <= nxt_state;
   end

   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         tdi_ff <= 1'b0;
         shift_dr_pend_ff <= 1'b0;
         shift_ir_pend_ff <= 1'b0;
      end
      else if (tck_rise)
      begin
         tdi_ff <= pins_s.tdi;
         shift_dr_pend_ff <= (state_ff == jdb_pkg::TAP_SHIFT_DR);
         shift_ir_pend_ff <= (state_ff == jdb_pkg::TAP_SHIFT_IR);
      end
      else if (tck_fall)
      begin
         shift_dr_pend_ff <= 1'b0;
         shift_ir_pend_ff <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (srst)
         ir_sr_ff <= jdb_pkg::IR_CAPTURE_PAT;
      else if (tck_rise && state_ff == jdb_pkg::TAP_CAP_IR)
         ir_sr_ff <= jdb_pkg::IR_CAPTURE_PAT;
      else if (tck_fall && shift_ir_pend_ff)
         ir_sr_ff <= {tdi_ff, ir_sr_ff[jdb_pkg::IR_W-1:1]};
   end

   assign ir_load = tck_fall && (state_ff == jdb_pkg::TAP_UPD_IR) && !chip_standby;

   always_ff @(posedge ref_clk)
   begin
      if (srst || !pins_s.trst_n || state_ff == jdb_pkg::TAP_RESET)
         ir_ff <= jdb_pkg::IR_BYPASS;
      else if (ir_load)
         ir_ff <= (ir_sr_ff == jdb_pkg::IR_INT) ? jdb_pkg::IR_BYPASS : ir_sr_ff;
   end

   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         irq_ff <= 1'b0;
         irq_level_ff <= jdb_pkg::IRQ_LEVEL_RST;
      end
      else
      begin
         irq_ff <= ir_load && (ir_sr_ff == jdb_pkg::IR_INT) && !chip_sleep;
         if (ir_load && ir_sr_ff == jdb_pkg::IR_INT && !chip_sleep)
            irq_level_ff <= jdb_pkg::IRQ_PRIORITY;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         wake_ff <= 1'b0;
         boot_ff <= 1'b0;
      end
      else
      begin
         wake_ff <= ir_load && (ir_sr_ff == jdb_pkg::IR_WAKE) && chip_sleep;
         boot_ff <= ir_load && (ir_sr_ff == jdb_pkg::IR_BOOT);
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (srst || !pins_s.trst_n)
         rst_cmd_ff <= 1'b0;
      else if (ir_load && ir_sr_ff == jdb_pkg::IR_RST_ON)
         rst_cmd_ff <= 1'b1;
      else if (ir_load && ir_sr_ff == jdb_pkg::IR_RST_OFF)
         rst_cmd_ff <= 1'b0;
   end

   // other codes fall back to bypass
   assign sel_bs = (ir_ff == jdb_pkg::IR_SAMPLE) || (ir_ff == jdb_pkg::IR_EXTEST);

   always_ff @(posedge ref_clk)
   begin
      if (srst)
         bypass_ff <= 1'b0;
      else if (tck_rise && state_ff == jdb_pkg::TAP_CAP_DR && !sel_bs)
         bypass_ff <= 1'b0;
      else if (tck_fall && shift_dr_pend_ff && !sel_bs)
         bypass_ff <= tdi_ff;
   end

   assign bs_ctl = '{capture: tck_rise && state_ff == jdb_pkg::TAP_CAP_DR && sel_bs,
                     shift: tck_fall && shift_dr_pend_ff && sel_bs,
                     update: tck_fall && state_ff == jdb_pkg::TAP_UPD_DR && sel_bs,
                     tdi: tdi_ff};

   jdb_bscan u_bscan (
      .ref_clk(ref_clk),
      .srst(srst),
      .ctl(bs_ctl),
      .bus_clk(pins_s.bus_clk),
      .pin_in(pins_s.pin_in),
      .core_out(core_out),
      .core_oe_n(core_oe_n),
      .chain_low(bs_low),
      .out_latch(out_latch),
      .oe_n_latch(oe_n_latch)
   );

   always_ff @(posedge ref_clk)
   begin
      if (srst)
         tdo_ff <= 1'b0;
      else if (tck_fall && state_ff == jdb_pkg::TAP_SHIFT_IR)
         tdo_ff <= shift_ir_pend_ff ? ir_sr_ff[1] : ir_sr_ff[0];
      else if (tck_fall && state_ff == jdb_pkg::TAP_SHIFT_DR)
      begin
         if (sel_bs)
            tdo_ff <= shift_dr_pend_ff ? bs_low[1] : bs_low[0];
         else
            tdo_ff <= shift_dr_pend_ff ? tdi_ff : bypass_ff;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (srst)
         tdo_oe_ff <= 1'b0;
      else
         tdo_oe_ff <= (state_ff == jdb_pkg::TAP_SHIFT_DR) || (state_ff == jdb_pkg::TAP_SHIFT_IR);
   end

   always_ff @(posedge ref_clk)
   begin
      if (srst)
         por_d_ff <= 1'b0;
      else
         por_d_ff <= pins_s.por_n;
   end

   always_ff @(posedge ref_clk)
   begin
      if (srst)
         hold_ff <= 1'b0;
      else if (!pins_s.emu_sel && !pins_s.por_n && !pins_s.trst_n)
         hold_ff <= 1'b1;
      else if (boot_ff || (por_d_ff && !pins_s.por_n))
         hold_ff <= 1'b0;
   end

   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         chip_reset_ff <= 1'b1;
         debug_reset_ff <= 1'b1;
         cpu_hold_ff <= 1'b0;
      end
      else
      begin
         chip_reset_ff <= !pins_s.por_n || rst_cmd_ff;
         debug_reset_ff <= !pins_s.trst_n;
         cpu_hold_ff <= hold_ff;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         pin_out_ff <= '0;
         pin_oe_ff <= '0;
         core_in_ff <= '0;
      end
      else
      begin
         pin_out_ff <= (ir_ff == jdb_pkg::IR_EXTEST) ? out_latch : core_out;
         pin_oe_ff <= (ir_ff == jdb_pkg::IR_EXTEST) ? ~oe_n_latch : ~core_oe_n;
         core_in_ff <= pins_s.pin_in;
      end
   end

   assign tdo = tdo_ff;
   assign tdo_oe = tdo_oe_ff;
   assign chip_reset = chip_reset_ff;
   assign debug_reset = debug_reset_ff;
   assign cpu_hold = cpu_hold_ff;
   assign debug_irq = irq_ff;
   assign debug_irq_level = irq_level_ff;
   assign wake_req = wake_ff;
   assign debug_instruction_reg = ir_ff;
   assign pin_out = pin_out_ff;
   assign pin_oe = pin_oe_ff;
   assign core_in = core_in_ff;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (srst);

   a_trst_forces_reset: assert property (!pins_s.trst_n |=> state_ff == jdb_pkg::TAP_RESET)
      else $error("TAP not in reset after test reset low");
   a_tms_leaves_select: assert property (tck_rise && pins_s.tms && state_ff == jdb_pkg::TAP_SEL_IR && pins_s.trst_n
      |=> state_ff == jdb_pkg::TAP_RESET)
      else $error("Select-IR with TMS high did not reach reset");
   a_tdo_idle_hiz: assert property (state_ff == jdb_pkg::TAP_IDLE ##1 state_ff == jdb_pkg::TAP_IDLE |-> !tdo_oe)
      else $error("TDO driven outside shift");
   a_irq_priority: assert property ($rose(debug_irq) |-> debug_irq_level == jdb_pkg::IRQ_PRIORITY
      && debug_instruction_reg == jdb_pkg::IR_BYPASS)
      else $error("Interrupt without priority 15 or bypass revert");
   a_irq_not_asleep: assert property (debug_irq |-> !$past(chip_sleep) && !$past(chip_standby))
      else $error("Interrupt raised in sleep or standby");
   a_rst_cmd_holds: assert property (rst_cmd_ff |=> chip_reset)
      else $error("Reset command did not hold chip reset");
   a_standby_no_load: assert property (chip_standby && tck_fall |=> $stable(debug_instruction_reg)
      || debug_instruction_reg == jdb_pkg::IR_BYPASS)
      else $error("Command loaded during standby");
   a_extest_drive: assert property (ir_ff == jdb_pkg::IR_EXTEST && $stable(ir_ff) |=> pin_out == $past(out_latch)
      && pin_oe == ~$past(oe_n_latch))
      else $error("Extest pins not driven from latches");
   a_hold_cpu: assert property (hold_ff |=> cpu_hold)
      else $error("Reset hold not reflected on CPU hold");
   a_wake_in_sleep: assert property (wake_req |-> $past(chip_sleep))
      else $error("Wake request outside sleep");
endmodule : jdb_top

/* dv/jdb_host.sv */
// Behavioural test host that drives the serial debug pins and the bus clock.
`timescale 1ns/1ps
module jdb_host (
   output logic tck,
   output logic tms,
   output logic tdi,
   output logic bus_clk,
   input wire logic tdo,
   input wire logic tdo_oe
);
   logic oe_on;
   logic oe_off;
   initial
   begin
      {tck, tms, tdi, bus_clk} = 4'h4;
      {oe_on, oe_off} = 2'h0;
   end
   always #125 bus_clk = ~bus_clk;
   // one test clock period
   // The output is read mid high phase, since the port answers several reference cycles after a fall.
   task automatic tick(input logic m, input logic d, output logic q);
      tms = m;
      tdi = d;
      #80 tck = 1'b1;
      // A released line shows the inverse of its last value, so a late enable is caught.
      #40 q = tdo_oe ? tdo : ~tdo;
      oe_off = tdo_oe;
      #40 tck = 1'b0;
   endtask : tick
   // idle to shift state and back
   // Outside the shift bits the data line toggles, so a stale value never looks valid.
   task automatic scan(input logic ir, input int n, input logic [24:0] din, output logic [24:0] dout);
      logic q;
      dout = 25'h0;
      oe_on = 1'b1;
      #7;
      tick(1'b0, ~tdi, q);
      tick(1'b1, ~tdi, q);
      if (ir)
         tick(1'b1, ~tdi, q);
      tick(1'b0, ~tdi, q);
      tick(1'b0, ~tdi, q);
      for (int i = 0; i < n; i++)
      begin
         tick(i == n - 1, din[i], q);
         dout[i] = q;
         oe_on = oe_on & oe_off;
      end
      tick(1'b1, ~tdi, q);
      tick(1'b0, ~tdi, q);
      tick(1'b0, ~tdi, q);
   endtask : scan
endmodule : jdb_host

/* dv/jdb_top_tb.sv */
// Self-checking testbench for the serial debug and boundary scan port.
`timescale 1ns/1ps
module jdb_top_tb;
   logic ref_clk = 1'b0;
   logic srst = 1'b1;
   logic trst_n = 1'b1;
   logic por_n = 1'b1;
   logic emu_sel = 1'b1;
   logic sleep = 1'b0;
   logic standby = 1'b0;
   logic [7:0] pin_in = 8'h00;
   logic [7:0] core_out = 8'h00;
   logic [7:0] core_oe_n = 8'hFF;
   logic tck, tms, tdi, bus_clk, tdo, tdo_oe, chip_reset, debug_reset, cpu_hold, debug_irq, wake_req;
   logic [7:0] pin_out, pin_oe, core_in;
   logic [3:0] irq_level, ir_reg;
   int errors = 0;
   int samples_checked = 0;
   int irq_cnt = 0;
   int wake_cnt = 0;

   jdb_host host_u (.tck(tck), .tms(tms), .tdi(tdi), .bus_clk(bus_clk), .tdo(tdo), .tdo_oe(tdo_oe));

   jdb_top dut_u (
      .ref_clk(ref_clk), .srst(srst), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n),
      .tdo(tdo), .tdo_oe(tdo_oe), .power_on_reset_pin_n(por_n), .emulator_mode_select(emu_sel),
      .bus_clock_pin(bus_clk), .chip_sleep(sleep), .chip_standby(standby), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe(pin_oe), .core_out(core_out), .core_oe_n(core_oe_n), .core_in(core_in),
      .chip_reset(chip_reset), .debug_reset(debug_reset), .cpu_hold(cpu_hold), .debug_irq(debug_irq),
      .debug_irq_level(irq_level), .wake_req(wake_req), .debug_instruction_reg(ir_reg)
   );

   initial
   begin
      forever #10 ref_clk = ~ref_clk;
   end

   always @(posedge ref_clk)
   begin
      irq_cnt <= irq_cnt + int'(debug_irq === 1'b1);
      wake_cnt <= wake_cnt + int'(wake_req === 1'b1);
   end

   task automatic check(input logic [24:0] seen, input logic [24:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic summarize();
      $display("checks %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : summarize

   task automatic settle();
      repeat (8) @(posedge ref_clk);
   endtask : settle

   function automatic logic [24:0] chain(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
      logic [24:0] v;
      v = 25'h0;
      for (int p = 0; p < 8; p++)
         v[3 * p + 1 +: 3] = {c[p], b[p], a[p]};
      return v;
   endfunction : chain

   task automatic ir(input logic [3:0] code);
      logic [24:0] q;
      host_u.scan(1'b1, 4, 25'(code), q);
      check(q, 25'(jdb_pkg::IR_CAPTURE_PAT));
      check(25'({host_u.oe_on, host_u.oe_off}), 25'h2);
      settle();
   endtask : ir

   task automatic t_bypass();
      logic [24:0] q;
      logic [3:0] codes [2] = '{jdb_pkg::IR_BYPASS, 4'hA};
      foreach (codes[k])
      begin
         ir(codes[k]);
         host_u.scan(1'b0, 3, 25'h3, q);
         check(q, 25'h6);
      end
      $display("test bypass done");
   endtask : t_bypass

   task automatic t_reset();
      logic q;
      ir(jdb_pkg::IR_RST_ON);
      check(25'(chip_reset), 25'h1);
      ir(jdb_pkg::IR_BYPASS);
      check(25'(chip_reset), 25'h1);
      ir(jdb_pkg::IR_RST_OFF);
      check(25'(chip_reset), 25'h0);
      ir(jdb_pkg::IR_SAMPLE);
      // Three high mode-select bits walk idle to select-DR, select-IR and test-logic-reset.
      #7;
      repeat (3) host_u.tick(1'b1, 1'b0, q);
      settle();
      check(25'(ir_reg), 25'(jdb_pkg::IR_BYPASS));
      ir(jdb_pkg::IR_SAMPLE);
      trst_n <= 1'b0;
      settle();
      check(25'({ir_reg, tdo_oe}), 25'h1E);
      for (int k = 0; k < 4; k++)
      begin
         {por_n, trst_n} <= 2'(k);
         settle();
         check(25'({chip_reset, debug_reset, cpu_hold}), 25'({~por_n, ~trst_n, 1'b0}));
      end
      $display("test reset done");
   endtask : t_reset

   task automatic t_cmds();
      int n;
      n = irq_cnt;
      ir(jdb_pkg::IR_INT);
      check(25'(irq_cnt - n), 25'h1);
      check(25'({irq_level, ir_reg}), 25'({jdb_pkg::IRQ_PRIORITY, jdb_pkg::IR_BYPASS}));
      sleep <= 1'b1;
      n = wake_cnt;
      ir(jdb_pkg::IR_WAKE);
      check(25'(wake_cnt - n), 25'h1);
      check(25'(ir_reg), 25'(jdb_pkg::IR_WAKE));
      n = irq_cnt;
      ir(jdb_pkg::IR_INT);
      check(25'(irq_cnt - n), 25'h0);
      sleep <= 1'b0;
      ir(jdb_pkg::IR_SAMPLE);
      standby <= 1'b1;
      ir(jdb_pkg::IR_INT);
      check(25'(irq_cnt - n), 25'h0);
      check(25'(ir_reg), 25'(jdb_pkg::IR_SAMPLE));
      standby <= 1'b0;
      $display("test commands done");
   endtask : t_cmds

   task automatic t_hold();
      emu_sel <= 1'b0;
      {por_n, trst_n} <= 2'h0;
      settle();
      check(25'(cpu_hold), 25'h1);
      por_n <= 1'b1;
      settle();
      trst_n <= 1'b1;
      settle();
      check(25'({cpu_hold, chip_reset, debug_reset}), 25'h4);
      ir(jdb_pkg::IR_BOOT);
      check(25'(cpu_hold), 25'h0);
      {por_n, trst_n} <= 2'h0;
      settle();
      {por_n, trst_n} <= 2'h3;
      settle();
      check(25'(cpu_hold), 25'h1);
      por_n <= 1'b0;
      settle();
      check(25'(cpu_hold), 25'h0);
      $display("test hold done");
   endtask : t_hold

   // Reset pin stays low and emulator select low from the hold test, as a scan host must keep them.
   task automatic t_boundary();
      logic [24:0] q;
      pin_in <= 8'hA5;
      core_out <= 8'h3C;
      core_oe_n <= 8'h0F;
      ir(jdb_pkg::IR_SAMPLE);
      check(25'({core_in, pin_out, pin_oe}), 25'(24'hA5_3CF0));
      host_u.scan(1'b0, 25, chain(8'h5A, 8'h96, 8'hF0), q);
      check(q & 25'h1FF_FFFE, chain(8'hA5, 8'h3C, 8'h0F));
      ir(jdb_pkg::IR_EXTEST);
      check(25'({pin_out & pin_oe, pin_oe}), 25'(16'h060F));
      pin_in <= 8'hC3;
      host_u.scan(1'b0, 25, chain(8'h00, 8'hFF, 8'h00), q);
      check(q & chain(8'hFF, 8'h00, 8'h00), chain(8'hC3, 8'h00, 8'h00));
      settle();
      check(25'({pin_out, pin_oe}), 25'(16'hFFFF));
      $display("test boundary done");
   endtask : t_boundary

   initial
   begin
      repeat (2) @(posedge ref_clk);
      srst <= 1'b0;
      settle();
      check(25'({irq_level, ir_reg, chip_reset, debug_reset, cpu_hold}),
            25'({jdb_pkg::IRQ_LEVEL_RST, jdb_pkg::IR_BYPASS, 3'h0}));
      t_bypass();
      t_reset();
      t_cmds();
      t_hold();
      t_boundary();
      summarize();
   end

   // Nineteen scans of under six microseconds each fit well inside this span.
   initial
   begin
      #1_000_000;
      errors++;
      summarize();
   end
endmodule : jdb_top_tb
